// ===== bcf_pkg.sv
// Constants, register map and state type of the backlight configuration
// and fault register bank.
// Assumes a 250 MHz device clock and a serial host on the two-wire port.
package bcf_pkg;

   // ******************************
   // Serial port
   // ******************************
   localparam logic [6:0] DEV_ADDR = 7'h38;

   // ******************************
   // Register offsets
   // ******************************
   localparam logic [7:0] REG_CFG = 8'h01;
   localparam logic [7:0] REG_FLT = 8'h02;
   localparam logic [7:0] REG_ID = 8'h03;

   // ******************************
   // Field positions
   // ******************************
   localparam int CFG_PHASE_BIT = 7;
   localparam int CFG_THR_LSB = 5;
   localparam int CFG_SWITCHING_RATE_PIN_LSB = 3;
   localparam int CFG_CNT_LSB = 0;
   localparam int FLT_GUARD_BIT = 7;
   localparam int FLT_SAT_BIT = 6;
   localparam int FLT_GROUND_BIT = 5;
   localparam int NUM_FLAGS = 6;

   // ******************************
   // Reset values and codes
   // ******************************
   localparam logic [7:0] CFG_RESET = 8'h28;
   localparam logic [5:0] FLAGS_RESET = 6'h00;
   localparam logic [5:0] ALL_SINKS = 6'h3f;
   localparam logic [5:0] FIRST_SINK = 6'h01;
   localparam logic [2:0] MAX_COUNT_CODE = 3'h5;
   // Arbitrary identifier value
   localparam logic [7:0] DEVICE_ID_DEFAULT = 8'h5a;

   // ******************************
   // Timing
   // ******************************
   localparam int CLK_KHZ = 250000;
   localparam int SAT_SHORT_MS = 20;
   localparam int SAT_LONG_MS = 40;
   localparam int SAT_SHORT_CYC = SAT_SHORT_MS * CLK_KHZ;
   localparam int SAT_LONG_CYC = SAT_LONG_MS * CLK_KHZ;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DEV  = 3'b001,
      ST_REG  = 3'b010,
      ST_WR   = 3'b011,
      ST_ACK  = 3'b100,
      ST_RD   = 3'b101,
      ST_MACK = 3'b110
   } bcf_state_t;

   // Reserved codes fall back to sink one only
   function automatic logic [5:0] bcf_sink_mask(input logic [2:0] code);
      if (code > MAX_COUNT_CODE) begin
         bcf_sink_mask = FIRST_SINK;
      end else begin
         bcf_sink_mask = ALL_SINKS >> code;
      end
   endfunction

endpackage

// ===== bcf_regs.sv
// Configuration, fault status and identifier registers of the LED driver,
// reached over the two-wire serial slave port.
// Assumes SCL/SDA already synchronous to CLK_I and an external open-drain pad.
`timescale 1ns/1ps
`default_nettype none

module bcf_regs
   import bcf_pkg::*;
#(
   parameter logic [7:0] DEVICE_ID = DEVICE_ID_DEFAULT,
   parameter int CNT_W = 24,
   parameter int SAT_SHORT_CYCLES = SAT_SHORT_CYC,
   parameter int SAT_LONG_CYCLES = SAT_LONG_CYC
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // Serial port, SDA is open drain
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_N_O,
   // Protection events
   input wire logic COMP_SATURATED_I,
   input wire logic [4:0] FAULT_EVENT_I,
   // Configuration to the analog core, and the fault flags
   output logic PHASE_OFFSET_ENABLE_O,
   output logic [1:0] SHORT_THRESHOLD_SEL_O,
   output logic [1:0] SWITCH_SWITCHING_RATE_PIN_SEL_O,
   output logic [2:0] ACTIVE_STRING_COUNT_O,
   output logic [5:0] SINK_ENABLE_O,
   output logic ALL_STRING_SHORT_GUARD_EN_O,
   output logic ERROR_AMP_SATURATION_TIME_SEL_O,
   output logic [5:0] FAULT_FLAGS_O
);

   // ******************************
   // State
   // ******************************
   logic scl_q, scl_p, sda_q, sda_p;
   logic next_scl_q, next_scl_p, next_sda_q, next_sda_p;
   bcf_state_t state, next_state, after_ack, next_after_ack;
   logic [7:0] shreg, next_shreg, ptr, next_ptr, cfg, next_cfg;
   logic [3:0] bitcnt, next_bitcnt;
   logic guard_en, next_guard_en, sat_sel, next_sat_sel, sda_oe_n, next_sda_oe_n;
   logic [5:0] flags, next_flags, clr_mask, set_mask, sink_en, next_sink_en;
   logic [CNT_W-1:0] sat_cnt, next_sat_cnt, sat_limit;
   logic start, stop, scl_rise, scl_fall, wr_en, rd_load, sat_trip;
   logic [7:0] rd_data, flt_word;

   assign start = scl_q & scl_p & sda_p & ~sda_q;
   assign stop = scl_q & scl_p & ~sda_p & sda_q;
   assign scl_rise = scl_q & ~scl_p;
   assign scl_fall = ~scl_q & scl_p;
   assign flt_word = {guard_en, sat_sel, flags};

   // ******************************
   // Read mux
   // ******************************
   always_comb begin
      case (ptr)
         REG_CFG: rd_data = cfg;
         REG_FLT: rd_data = flt_word;
         REG_ID: rd_data = DEVICE_ID;
         default: rd_data = 8'h00;
      endcase
   end

   // ******************************
   // Serial slave
   // ******************************
   always_comb begin
      next_scl_q = SCL_I;
      next_scl_p = scl_q;
      next_sda_q = SDA_I;
      next_sda_p = sda_q;
      next_state = state;
      next_after_ack = after_ack;
      next_shreg = shreg;
      next_ptr = ptr;
      next_bitcnt = bitcnt;
      next_sda_oe_n = sda_oe_n;
      wr_en = 1'b0;
      rd_load = 1'b0;
      if (start) begin
         next_state = ST_DEV;
         next_bitcnt = 4'h0;
         next_sda_oe_n = 1'b1;
      end else if (stop) begin
         next_state = ST_IDLE;
         next_sda_oe_n = 1'b1;
      end else begin
         case (state)
            ST_DEV, ST_REG, ST_WR: begin
               if (scl_rise) begin
                  next_shreg = {shreg[6:0], sda_q};
                  next_bitcnt = bitcnt + 4'h1;
               end else if (scl_fall && bitcnt == 4'h8) begin
                  next_bitcnt = 4'h0;
                  next_state = ST_ACK;
                  next_sda_oe_n = 1'b0;
                  if (state == ST_DEV) begin
                     if (shreg[7:1] == DEV_ADDR) begin
                        next_after_ack = shreg[0] ? ST_RD : ST_REG;
                     end else begin
                        next_state = ST_IDLE;
                        next_sda_oe_n = 1'b1;
                     end
                  end else if (state == ST_REG) begin
                     next_ptr = shreg;
                     next_after_ack = ST_WR;
                  end else begin
                     wr_en = 1'b1;
                     next_ptr = ptr + 8'h01;
                     next_after_ack = ST_WR;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  next_sda_oe_n = 1'b1;
                  next_bitcnt = 4'h0;
                  next_state = after_ack;
                  rd_load = (after_ack == ST_RD);
               end
            end
            ST_RD: begin
               if (scl_fall) begin
                  if (bitcnt == 4'h7) begin
                     next_sda_oe_n = 1'b1;
                     next_bitcnt = 4'h0;
                     next_state = ST_MACK;
                  end else begin
                     next_bitcnt = bitcnt + 4'h1;
                     next_shreg = {shreg[6:0], 1'b0};
                     next_sda_oe_n = shreg[6];
                  end
               end
            end
            ST_MACK: begin
               // Host NACK ends the burst
               if (scl_rise) begin
                  next_bitcnt = 4'h1;
                  next_state = sda_q ? ST_IDLE : ST_MACK;
               end else if (scl_fall && bitcnt == 4'h1) begin
                  next_bitcnt = 4'h0;
                  next_state = ST_RD;
                  rd_load = 1'b1;
               end
            end
            default: next_state = ST_IDLE;
         endcase
      end
      if (rd_load) begin
         next_shreg = rd_data;
         next_sda_oe_n = rd_data[7];
         next_ptr = ptr + 8'h01;
      end
   end

   // ******************************
   // Registers and fault flags
   // ******************************
   always_comb begin
      sat_limit = sat_sel ? CNT_W'(SAT_LONG_CYCLES) : CNT_W'(SAT_SHORT_CYCLES);
      sat_trip = COMP_SATURATED_I && (sat_cnt == sat_limit - CNT_W'(1));
      next_sat_cnt = sat_cnt;
      // Less-than, so a shorter limit picked mid-run cannot let the count wrap
      if (!COMP_SATURATED_I) begin
         next_sat_cnt = '0;
      end else if (sat_cnt < sat_limit) begin
         next_sat_cnt = sat_cnt + CNT_W'(1);
      end
      next_cfg = cfg;
      next_guard_en = guard_en;
      next_sat_sel = sat_sel;
      if (wr_en && ptr == REG_CFG) begin
         next_cfg = shreg;
      end
      if (wr_en && ptr == REG_FLT) begin
         // Only the two control bits take write data
         next_guard_en = shreg[FLT_GUARD_BIT];
         next_sat_sel = shreg[FLT_SAT_BIT];
      end
      // Captured bits clear on the same edge as the shift load; a same-cycle event wins
      clr_mask = (rd_load && ptr == REG_FLT) ? flags : 6'h00;
      set_mask[5] = sat_trip;
      set_mask[4:3] = FAULT_EVENT_I[4:3];
      set_mask[2:0] = FAULT_EVENT_I[2:0];
      next_flags = (flags & ~clr_mask) | set_mask;
      next_sink_en = bcf_sink_mask(cfg[CFG_CNT_LSB +: 3]);
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         scl_q <= 1'b1;
         scl_p <= 1'b1;
         sda_q <= 1'b1;
         sda_p <= 1'b1;
         state <= ST_IDLE;
         after_ack <= ST_IDLE;
         shreg <= 8'h00;
         ptr <= 8'h00;
         bitcnt <= 4'h0;
         sda_oe_n <= 1'b1;
         cfg <= CFG_RESET;
         guard_en <= 1'b0;
         sat_sel <= 1'b0;
         flags <= FLAGS_RESET;
         sat_cnt <= '0;
         sink_en <= ALL_SINKS;
         SDA_O <= 1'b0;
      end else begin
         scl_q <= next_scl_q;
         scl_p <= next_scl_p;
         sda_q <= next_sda_q;
         sda_p <= next_sda_p;
         state <= next_state;
         after_ack <= next_after_ack;
         shreg <= next_shreg;
         ptr <= next_ptr;
         bitcnt <= next_bitcnt;
         sda_oe_n <= next_sda_oe_n;
         cfg <= next_cfg;
         guard_en <= next_guard_en;
         sat_sel <= next_sat_sel;
         flags <= next_flags;
         sat_cnt <= next_sat_cnt;
         sink_en <= next_sink_en;
         // Open drain: the pad only ever pulls low
         SDA_O <= 1'b0;
      end
   end

   assign SDA_OE_N_O = sda_oe_n;
   assign PHASE_OFFSET_ENABLE_O = cfg[CFG_PHASE_BIT];
   assign SHORT_THRESHOLD_SEL_O = cfg[CFG_THR_LSB +: 2];
   assign SWITCH_SWITCHING_RATE_PIN_SEL_O = cfg[CFG_SWITCHING_RATE_PIN_LSB +: 2];
   assign ACTIVE_STRING_COUNT_O = cfg[CFG_CNT_LSB +: 3];
   assign SINK_ENABLE_O = sink_en;
   assign ALL_STRING_SHORT_GUARD_EN_O = guard_en;
   assign ERROR_AMP_SATURATION_TIME_SEL_O = sat_sel;
   assign FAULT_FLAGS_O = flags;

   // ******************************
   // Assertions
   // ******************************
   property p_phase;
      @(posedge CLK_I) disable iff (RESET_I)
      wr_en && ptr == REG_CFG |=> PHASE_OFFSET_ENABLE_O == $past(shreg[7]);
   endproperty
   a_phase: assert property (p_phase) else $error("phase enable not written");

   property p_fields;
      @(posedge CLK_I) disable iff (RESET_I)
      wr_en && ptr == REG_CFG |=> {SHORT_THRESHOLD_SEL_O, SWITCH_SWITCHING_RATE_PIN_SEL_O} == $past(shreg[6:3]);
   endproperty
   a_fields: assert property (p_fields) else $error("threshold or frequency wrong");

   property p_sinks;
      @(posedge CLK_I) disable iff (RESET_I)
      wr_en && ptr == REG_CFG && shreg[2:0] == 3'h2 |=> ##1 SINK_ENABLE_O == 6'h0f;
   endproperty
   a_sinks: assert property (p_sinks) else $error("sink mask wrong");

   property p_guard;
      @(posedge CLK_I) disable iff (RESET_I)
      wr_en && ptr == REG_FLT |=> {guard_en, sat_sel} == $past(shreg[7:6]);
   endproperty
   a_guard: assert property (p_guard) else $error("fault control bits wrong");

   property p_sat_time;
      @(posedge CLK_I) disable iff (RESET_I)
      $rose(flags[FLT_GROUND_BIT]) |-> $past(COMP_SATURATED_I)
         && $past(sat_cnt) == ($past(sat_sel) ? CNT_W'(SAT_LONG_CYCLES - 1)
                                              : CNT_W'(SAT_SHORT_CYCLES - 1));
   endproperty
   a_sat_time: assert property (p_sat_time) else $error("saturation trip at wrong count");

   property p_ground;
      @(posedge CLK_I) disable iff (RESET_I)
      sat_trip |=> flags[FLT_GROUND_BIT];
   endproperty
   a_ground: assert property (p_ground) else $error("ground short flag not set");

   property p_events;
      @(posedge CLK_I) disable iff (RESET_I)
      FAULT_EVENT_I != 5'h00 |=> (flags[4:0] & $past(FAULT_EVENT_I)) == $past(FAULT_EVENT_I);
   endproperty
   a_events: assert property (p_events) else $error("fault event lost");

   property p_hold;
      @(posedge CLK_I) disable iff (RESET_I)
      !(rd_load && ptr == REG_FLT) |=> (flags & $past(flags)) == $past(flags);
   endproperty
   a_hold: assert property (p_hold) else $error("flag dropped without read");

   property p_clear;
      @(posedge CLK_I) disable iff (RESET_I)
      rd_load && ptr == REG_FLT && sat_trip == 1'b0 && FAULT_EVENT_I == 5'h00
         |=> flags == 6'h00 && shreg[5:0] == $past(flags);
   endproperty
   a_clear: assert property (p_clear) else $error("read did not capture then clear");

   property p_id;
      @(posedge CLK_I) disable iff (RESET_I)
      rd_load && ptr == REG_ID |=> shreg == DEVICE_ID && !SDA_OE_N_O == !DEVICE_ID[7];
   endproperty
   a_id: assert property (p_id) else $error("identifier read wrong");

   property p_addr_ack;
      @(posedge CLK_I) disable iff (RESET_I)
      state == ST_DEV && scl_fall && bitcnt == 4'h8 && shreg[7:1] != DEV_ADDR && !start && !stop
         |=> state == ST_IDLE && SDA_OE_N_O;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("foreign address answered");

endmodule

`default_nettype wire

// ===== bcf_host.sv
// Serial host model for the two-wire port of the register bank.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module bcf_host
   import bcf_pkg::*;
(
   // Clock and resolved wire
   input wire logic clk_i,
   input wire logic sda_i,
   // Host drive, sda_low_o pulls the wire down
   output logic scl_o,
   output logic sda_low_o
);
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end

   // ***********************
   // Bit and byte timing
   // ***********************
   // Every change lands just after an edge, phases of 4 or 8 cycles, 16 cycles per bit
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // Also used as repeated start
   task automatic start_cond();
      sda_low_o = 1'b0;
      tick(4);
      scl_o = 1'b1;
      tick(8);
      sda_low_o = 1'b1;
      tick(8);
      scl_o = 1'b0;
      tick(4);
   endtask

   task automatic stop_cond();
      sda_low_o = 1'b1;
      tick(4);
      scl_o = 1'b1;
      tick(8);
      sda_low_o = 1'b0;
      tick(8);
   endtask

   task automatic put_bit(input logic b);
      sda_low_o = ~b;
      tick(4);
      scl_o = 1'b1;
      tick(8);
      scl_o = 1'b0;
      tick(4);
   endtask

   // Sample mid-high, well after the slave has settled the wire
   task automatic get_bit(output logic b);
      sda_low_o = 1'b0;
      tick(4);
      scl_o = 1'b1;
      tick(4);
      b = sda_i;
      tick(4);
      scl_o = 1'b0;
      tick(4);
   endtask

   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i]);
      end
      get_bit(b);
      ack = ~b;
   endtask

   // A last byte is refused with a high ninth bit
   task automatic get_byte(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         get_bit(d[i]);
      end
      put_bit(last);
   endtask

   task automatic reg_write(input logic [6:0] dev, input logic [7:0] ra,
                            input logic [7:0] d, output logic [2:0] ack);
      start_cond();
      put_byte({dev, 1'b0}, ack[2]);
      put_byte(ra, ack[1]);
      put_byte(d, ack[0]);
      stop_cond();
   endtask

   task automatic reg_read(input logic [7:0] ra, output logic [7:0] d);
      logic a;
      start_cond();
      put_byte({DEV_ADDR, 1'b0}, a);
      put_byte(ra, a);
      start_cond();
      put_byte({DEV_ADDR, 1'b1}, a);
      get_byte(1'b1, d);
      stop_cond();
   endtask
endmodule
`default_nettype wire

// ===== test_backlight_config_fault_regs.sv
// Self-checking bench of the configuration and fault register bank.
// Assumes the host model in bcf_host and a pull-up on the data wire.
`timescale 1ns/1ps
`default_nettype none
module test_backlight_config_fault_regs;
   import bcf_pkg::*;
   localparam logic [7:0] TB_ID = 8'hc3; // Arbitrary identifier value
   logic clk, rst, comp_sat, scl, sda_low, sda_o, sda_oe_n, phase, guard, sat_sel;
   logic [1:0] thr, switching_rate_pin;
   logic [2:0] cnt, ack;
   logic [4:0] fault_ev, ev;
   logic [5:0] sinks, flags;
   logic [7:0] rd, cfg;
   int fail_count, checks, seed;
   wire sda = ~sda_low & (sda_oe_n | sda_o);

   // Short saturation limits keep the run brief
   bcf_regs #(.DEVICE_ID(TB_ID), .SAT_SHORT_CYCLES(20), .SAT_LONG_CYCLES(40)) i_dut (
      .CLK_I(clk), .RESET_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
      .SDA_OE_N_O(sda_oe_n), .COMP_SATURATED_I(comp_sat), .FAULT_EVENT_I(fault_ev),
      .PHASE_OFFSET_ENABLE_O(phase), .SHORT_THRESHOLD_SEL_O(thr),
      .SWITCH_SWITCHING_RATE_PIN_SEL_O(switching_rate_pin), .ACTIVE_STRING_COUNT_O(cnt), .SINK_ENABLE_O(sinks),
      .ALL_STRING_SHORT_GUARD_EN_O(guard), .ERROR_AMP_SATURATION_TIME_SEL_O(sat_sel),
      .FAULT_FLAGS_O(flags));
   bcf_host i_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ***********************
   // Helpers
   // ***********************
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic stop_test();
      if (fail_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   function automatic logic [5:0] exp_sink(input logic [2:0] c);
      return 6'h3f >> c;
   endfunction

   task automatic do_reset();
      rst = 1'b1;
      tick(4);
      rst = 1'b0;
      tick(4);
      chk("cfg", {1'b0, 2'h1, 2'h1, 3'h0}, {phase, thr, switching_rate_pin, cnt});
      chk("flt", 8'h00, {guard, sat_sel, flags});
      chk("sinks", {2'h0, exp_sink(3'h0)}, {2'h0, sinks});
   endtask

   // Flag must stay low through lo edges and be up by hi edges
   task automatic sat_probe(input int lo, input int hi);
      comp_sat = 1'b1;
      tick(lo);
      chk("sat early", 8'h00, {7'h0, flags[5]});
      tick(hi - lo);
      chk("sat flag", 8'h01, {7'h0, flags[5]});
      comp_sat = 1'b0;
   endtask

   initial begin
      #200000;
      fail_count++;
      stop_test();
   end

   // ***********************
   // Scenarios
   // ***********************
   initial begin
      seed = 58356;
      fail_count = 0;
      checks = 0;
      comp_sat = 1'b0;
      fault_ev = 5'h00;
      do_reset();
      i_host.reg_read(REG_CFG, rd);
      chk("cfg rd", {1'b0, 2'h1, 2'h1, 3'h0}, rd);
      i_host.reg_read(REG_ID, rd);
      chk("id rd", TB_ID, rd);
      i_host.reg_read(8'h04, rd);
      chk("unmapped rd", 8'h00, rd);
      // Sinks stay separate here, so phase shift may be used
      for (int i = 0; i < 6; i++) begin
         cfg = {i[0], i[1:0], ~i[1:0], i[2:0]};
         i_host.reg_write(DEV_ADDR, REG_CFG, cfg, ack);
         chk("ack", 8'h07, {5'h0, ack});
         chk("cfg out", cfg, {phase, thr, switching_rate_pin, cnt});
         chk("sinks", {2'h0, exp_sink(cfg[2:0])}, {2'h0, sinks});
         i_host.reg_read(REG_CFG, rd);
         chk("cfg rd", cfg, rd);
      end
      i_host.reg_write(DEV_ADDR ^ 7'h01, REG_CFG, 8'h00, ack);
      chk("nack", 8'h00, {5'h0, ack});
      chk("cfg kept", cfg, {phase, thr, switching_rate_pin, cnt});
      i_host.reg_write(DEV_ADDR, REG_FLT, 8'hff, ack);
      chk("flt out", 8'hc0, {guard, sat_sel, flags});
      i_host.reg_write(DEV_ADDR, REG_ID, 8'h00, ack);
      i_host.reg_read(REG_ID, rd);
      chk("id kept", TB_ID, rd);
      sat_probe(38, 40);
      i_host.reg_read(REG_FLT, rd);
      chk("flt rd", 8'he0, rd);
      chk("flags clr", 8'h00, {2'h0, flags});
      i_host.reg_write(DEV_ADDR, REG_FLT, 8'h80, ack);
      // A broken run must restart the count
      comp_sat = 1'b1;
      tick(15);
      comp_sat = 1'b0;
      tick(1);
      sat_probe(18, 20);
      i_host.reg_read(REG_FLT, rd);
      chk("flt rd", 8'ha0, rd);
      for (int i = 0; i < 10; i++) begin
         ev = 5'($random(seed)) | (5'h01 << (i % 5));
         fault_ev = ev;
         tick(1);
         fault_ev = 5'h00;
         tick(1);
         chk("flags", {3'h0, ev}, {2'h0, flags});
         tick(20);
         chk("held", {3'h0, ev}, {2'h0, flags});
         i_host.reg_read(REG_FLT, rd);
         chk("flt rd", {3'h4, ev}, rd);
         chk("flags clr", 8'h00, {2'h0, flags});
      end
      fault_ev = 5'h1f;
      tick(1);
      fault_ev = 5'h00;
      do_reset();
      stop_test();
   end

   initial begin
      rst = 1'b1;
   end
endmodule
`default_nettype wire
